// >>> rtl/bfb_frame_builder.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - key selector octet names the temporal key
// - protected payload uses the selected key
// - secure frames carry eight-octet integrity tag
// - check word covers key octet, fixed beacon fields, payload and tag
// - first octet lsb is highest coefficient
// - degree-32 generator polynomial
// - preset ones, send inverted remainder
// - check word bit 31 carries a0
// - receiver flags residue other than fixed value
// - beacon header fields fixed, broadcast destination
// - beacon subtype regular, signalling, echo
// - beacon sequence is superframe number
// - group founder initialises superframe number
// - adopt largest neighbour superframe number
// - beacon payload: id, slot, type, elements; id, slot and type sent in regular beacons only
// - elements in ascending identifier order; checked in regular beacons only
// - three mandatory elements in every beacon; checked in regular beacons only
// - device identifier is 48-bit unique id
// - slot byte: reserved, movable, 5-bit index
// - movable flag set when beacon relocatable
// - operation mode encoding in device type
// - security mode encoding, reserved bits zero
// - superframe counter wraps at 2048
module bfb_frame_builder #(
    parameter logic [5:0] MAX_BEACON_WINDOW_SLOTS = 6'h20,
    parameter logic [7:0] ID_PERIOD_OCCUPANCY = 8'h01,
    parameter logic [7:0] ID_RESERVATION_AVAIL = 8'h02,
    parameter logic [7:0] ID_QUIET_PERIOD = 8'h03
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // upper mac transmit octets
    input wire logic up_tx_valid,
    input wire bfb_pkg::bfb_byte_t up_tx,
    output logic up_tx_ready,
    input wire logic [63:0] integrity_tag,
    output logic [7:0] cipher_key_sel,
    // transmit header
    output bfb_pkg::bfb_hdr_t tx_hdr,
    output logic tx_hdr_valid,
    // physical layer transmit octets
    output logic phy_tx_valid,
    output bfb_pkg::bfb_byte_t phy_tx,
    input wire logic phy_tx_ready,
    // physical layer receive octets
    input wire logic phy_rx_valid,
    input wire bfb_pkg::bfb_byte_t phy_rx,
    output logic phy_rx_ready,
    input wire logic rx_is_beacon,
    input wire logic [10:0] rx_sfn,
    // upper mac receive octets
    output logic up_rx_valid,
    output bfb_pkg::bfb_byte_t up_rx,
    input wire logic up_rx_ready,
    output logic rx_crc_err,
    // superframe timing
    input wire logic superframe_tick
);

    typedef struct packed {
        bfb_pkg::bfb_tx_state_t tx_state;
        logic [3:0] cnt;
        logic [31:0] crc;
        logic secure;
        logic beacon;
        logic [3:0] subtype;
        logic out_v;
        bfb_pkg::bfb_byte_t out;
        bfb_pkg::bfb_hdr_t hdr;
        logic hdr_v;
        logic [1:0] ie_phase;
        logic [7:0] ie_left;
        logic [7:0] last_id;
        logic ie_any;
        logic [2:0] seen;
        logic [31:0] rx_crc;
        logic up_v;
        bfb_pkg::bfb_byte_t up;
        logic err_pulse;
        logic [10:0] sfn;
        logic [47:0] devid;
        logic [4:0] slot_idx;
        logic movable;
        logic [1:0] op_mode;
        logic [1:0] sec_mode;
        logic [15:0] src_addr;
        logic [15:0] dest_addr;
        logic [7:0] key_sel;
        logic crc_err;
        logic ie_order_err;
        logic ie_missing;
        logic [31:0] last_fcs;
        logic [31:0] rdata;
    } bfb_state_t;

    bfb_state_t st_ff;
    bfb_state_t nxt_st;
    logic load;
    logic emit;
    bfb_pkg::bfb_byte_t ebyte;
    logic rx_acc;
    logic rx_bad;
    logic rx_adopt;
    logic start;
    logic group_form;
    logic [31:0] rx_upd;
    logic [31:0] fcs_word;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        nxt_st.err_pulse = 1'b0;
        nxt_st.hdr_v = 1'b0;
        emit = 1'b0;
        ebyte = '0;
        rx_bad = 1'b0;
        rx_adopt = 1'b0;
        rx_upd = st_ff.rx_crc;
        fcs_word = ~st_ff.crc;
        load = !st_ff.out_v || phy_tx_ready;
        start = reg_wr && reg_addr == bfb_pkg::REG_CTRL
            && reg_wdata[bfb_pkg::CTRL_START];
        group_form = reg_wr && reg_addr == bfb_pkg::REG_CTRL
            && reg_wdata[bfb_pkg::CTRL_GROUP_FORM];

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                bfb_pkg::REG_DEVID_LO: nxt_st.devid[31:0] = reg_wdata;
                bfb_pkg::REG_DEVID_HI: nxt_st.devid[47:32] = reg_wdata[15:0];
                bfb_pkg::REG_BEACON_CFG: begin
                    if ({1'b0, reg_wdata[bfb_pkg::CFG_SLOT +: 5]}
                        < MAX_BEACON_WINDOW_SLOTS) begin
                        nxt_st.slot_idx = reg_wdata[bfb_pkg::CFG_SLOT +: 5];
                    end
                    nxt_st.movable = reg_wdata[bfb_pkg::CFG_MOVABLE];
                    nxt_st.op_mode = reg_wdata[bfb_pkg::CFG_OP_MODE +: 2];
                    if (reg_wdata[bfb_pkg::CFG_SEC_MODE +: 2]
                        != bfb_pkg::SEC_MODE_RSVD) begin
                        nxt_st.sec_mode = reg_wdata[bfb_pkg::CFG_SEC_MODE +: 2];
                    end
                end
                bfb_pkg::REG_ADDR: begin
                    nxt_st.src_addr = reg_wdata[bfb_pkg::ADDR_SRC +: 16];
                    nxt_st.key_sel = reg_wdata[bfb_pkg::ADDR_KEY_SEL +: 8];
                end
                bfb_pkg::REG_DEST: nxt_st.dest_addr = reg_wdata[15:0];
                bfb_pkg::REG_STATUS: begin
                    if (reg_wdata[bfb_pkg::STAT_CRC_ERR]) begin
                        nxt_st.crc_err = 1'b0;
                    end
                    if (reg_wdata[bfb_pkg::STAT_IE_ORDER]) begin
                        nxt_st.ie_order_err = 1'b0;
                    end
                    if (reg_wdata[bfb_pkg::STAT_IE_MISSING]) begin
                        nxt_st.ie_missing = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads
        if (reg_rd) begin
            unique case (reg_addr)
                bfb_pkg::REG_CTRL: nxt_st.rdata = {24'h000000, st_ff.subtype,
                    st_ff.beacon, 2'b00, st_ff.tx_state != bfb_pkg::TX_IDLE};
                bfb_pkg::REG_DEVID_LO: nxt_st.rdata = st_ff.devid[31:0];
                bfb_pkg::REG_DEVID_HI: nxt_st.rdata = {16'h0000,
                    st_ff.devid[47:32]};
                bfb_pkg::REG_BEACON_CFG: nxt_st.rdata = {20'h00000,
                    st_ff.sec_mode, st_ff.op_mode, 2'b00, st_ff.movable,
                    st_ff.slot_idx};
                bfb_pkg::REG_ADDR: nxt_st.rdata = {8'h00, st_ff.key_sel,
                    st_ff.src_addr};
                bfb_pkg::REG_STATUS: nxt_st.rdata = {12'h000,
                    st_ff.tx_state != bfb_pkg::TX_IDLE, st_ff.ie_missing,
                    st_ff.ie_order_err, st_ff.crc_err, 5'h00, st_ff.sfn};
                bfb_pkg::REG_LAST_FCS: nxt_st.rdata = st_ff.last_fcs;
                bfb_pkg::REG_DEST: nxt_st.rdata = {16'h0000, st_ff.dest_addr};
                default: nxt_st.rdata = '0;
            endcase
        end

        // transmit sequencer
        if (load) begin
            nxt_st.out_v = 1'b0;
        end
        up_tx_ready = st_ff.tx_state == bfb_pkg::TX_BODY && load;
        unique case (st_ff.tx_state)
            bfb_pkg::TX_IDLE: begin
                if (start) begin
                    nxt_st.beacon = reg_wdata[bfb_pkg::CTRL_BEACON];
                    nxt_st.secure = reg_wdata[bfb_pkg::CTRL_SECURE]
                        && !reg_wdata[bfb_pkg::CTRL_BEACON];
                    nxt_st.subtype = reg_wdata[bfb_pkg::CTRL_SUBTYPE +: 4];
                    if (reg_wdata[bfb_pkg::CTRL_SUBTYPE +: 4]
                        > bfb_pkg::SUB_ECHO) begin
                        nxt_st.subtype = bfb_pkg::SUB_REGULAR;
                    end
                    nxt_st.crc = bfb_pkg::CRC_INIT;
                    nxt_st.cnt = '0;
                    nxt_st.ie_phase = '0;
                    nxt_st.ie_any = 1'b0;
                    nxt_st.last_id = '0;
                    nxt_st.seen = '0;
                    nxt_st.hdr_v = 1'b1;
                    nxt_st.hdr = '0;
                    nxt_st.hdr.src = st_ff.src_addr;
                    if (reg_wdata[bfb_pkg::CTRL_BEACON]) begin
                        nxt_st.hdr.frame_type = bfb_pkg::FTYPE_BEACON;
                        nxt_st.hdr.dest = bfb_pkg::BROADCAST_DESTINATION_VALUE;
                        nxt_st.hdr.subtype = nxt_st.subtype;
                        nxt_st.hdr.seq = st_ff.sfn;
                    end else begin
                        nxt_st.hdr.frame_type = bfb_pkg::FTYPE_DATA;
                        nxt_st.hdr.dest = st_ff.dest_addr;
                        nxt_st.hdr.secure = reg_wdata[bfb_pkg::CTRL_SECURE];
                    end
                    if (nxt_st.secure) begin
                        nxt_st.tx_state = bfb_pkg::TX_KEY;
                    end else if (reg_wdata[bfb_pkg::CTRL_BEACON]
                        && nxt_st.subtype == bfb_pkg::SUB_REGULAR) begin
                        nxt_st.tx_state = bfb_pkg::TX_FIX;
                    end else begin
                        nxt_st.tx_state = bfb_pkg::TX_BODY;
                    end
                end
            end
            bfb_pkg::TX_KEY: begin
                if (load) begin
                    emit = 1'b1;
                    ebyte.data = st_ff.key_sel;
                    nxt_st.tx_state = bfb_pkg::TX_BODY;
                end
            end
            bfb_pkg::TX_FIX: begin
                if (load) begin
                    emit = 1'b1;
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                    if (st_ff.cnt < 4'h6) begin
                        ebyte.data = st_ff.devid[{st_ff.cnt[2:0], 3'b000} +: 8];
                    end else if (st_ff.cnt == 4'h6) begin
                        ebyte.data = {st_ff.slot_idx, st_ff.movable, 2'b00};
                    end else begin
                        ebyte.data = {4'h0, st_ff.sec_mode, st_ff.op_mode};
                    end
                    if (st_ff.cnt == bfb_pkg::FIX_LAST) begin
                        nxt_st.cnt = '0;
                        nxt_st.tx_state = bfb_pkg::TX_BODY;
                    end
                end
            end
            bfb_pkg::TX_BODY: begin
                if (load && up_tx_valid) begin
                    emit = 1'b1;
                    ebyte.data = up_tx.data;
                    if (st_ff.beacon && st_ff.subtype == bfb_pkg::SUB_REGULAR) begin
                        unique case (st_ff.ie_phase)
                            2'd0: begin
                                if (st_ff.ie_any && up_tx.data < st_ff.last_id) begin
                                    nxt_st.ie_order_err = 1'b1;
                                end
                                nxt_st.last_id = up_tx.data;
                                nxt_st.ie_any = 1'b1;
                                nxt_st.ie_phase = 2'd1;
                                if (up_tx.data == ID_PERIOD_OCCUPANCY) begin
                                    nxt_st.seen[0] = 1'b1;
                                end
                                if (up_tx.data == ID_RESERVATION_AVAIL) begin
                                    nxt_st.seen[1] = 1'b1;
                                end
                                if (up_tx.data == ID_QUIET_PERIOD) begin
                                    nxt_st.seen[2] = 1'b1;
                                end
                            end
                            2'd1: begin
                                nxt_st.ie_left = up_tx.data;
                                nxt_st.ie_phase = up_tx.data == 8'h00 ? 2'd0 : 2'd2;
                            end
                            default: begin
                                nxt_st.ie_left = st_ff.ie_left - 8'h01;
                                if (st_ff.ie_left == 8'h01) begin
                                    nxt_st.ie_phase = 2'd0;
                                end
                            end
                        endcase
                    end
                    if (up_tx.last) begin
                        nxt_st.cnt = '0;
                        nxt_st.tx_state = st_ff.secure ? bfb_pkg::TX_TAG
                            : bfb_pkg::TX_FCS;
                        if (st_ff.beacon && st_ff.subtype == bfb_pkg::SUB_REGULAR
                            && nxt_st.seen != 3'b111) begin
                            nxt_st.ie_missing = 1'b1;
                        end
                    end
                end
            end
            bfb_pkg::TX_TAG: begin
                if (load) begin
                    emit = 1'b1;
                    ebyte.data = integrity_tag[{st_ff.cnt[2:0], 3'b000} +: 8];
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                    if (st_ff.cnt == bfb_pkg::TAG_LAST) begin
                        nxt_st.cnt = '0;
                        nxt_st.tx_state = bfb_pkg::TX_FCS;
                    end
                end
            end
            bfb_pkg::TX_FCS: begin
                if (load) begin
                    emit = 1'b1;
                    ebyte.data = fcs_word[{st_ff.cnt[1:0], 3'b000} +: 8];
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                    if (st_ff.cnt == bfb_pkg::FCS_LAST) begin
                        ebyte.last = 1'b1;
                        nxt_st.cnt = '0;
                        nxt_st.last_fcs = fcs_word;
                        nxt_st.tx_state = bfb_pkg::TX_IDLE;
                    end
                end
            end
            default: nxt_st.tx_state = bfb_pkg::TX_IDLE;
        endcase
        if (emit) begin
            nxt_st.out_v = 1'b1;
            nxt_st.out = ebyte;
            if (st_ff.tx_state != bfb_pkg::TX_FCS) begin
                nxt_st.crc = bfb_pkg::crc_byte(st_ff.crc, ebyte.data);
            end
        end

        // receive path
        if (up_rx_ready) begin
            nxt_st.up_v = 1'b0;
        end
        phy_rx_ready = !st_ff.up_v || up_rx_ready;
        rx_acc = phy_rx_valid && phy_rx_ready;
        if (rx_acc) begin
            nxt_st.up_v = 1'b1;
            nxt_st.up = phy_rx;
            rx_upd = bfb_pkg::crc_byte(st_ff.rx_crc, phy_rx.data);
            nxt_st.rx_crc = rx_upd;
            if (phy_rx.last) begin
                nxt_st.rx_crc = bfb_pkg::CRC_INIT;
                if (bfb_pkg::rev32(rx_upd) != bfb_pkg::CRC_RESIDUE) begin
                    rx_bad = 1'b1;
                    nxt_st.err_pulse = 1'b1;
                    nxt_st.crc_err = 1'b1;
                end else if (rx_is_beacon && rx_sfn > st_ff.sfn) begin
                    rx_adopt = 1'b1;
                end
            end
        end

        // superframe counter
        if (superframe_tick) begin
            nxt_st.sfn = st_ff.sfn + 11'h001;
        end
        if (rx_adopt) begin
            nxt_st.sfn = rx_sfn;
        end
        if (group_form) begin
            nxt_st.sfn = '0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.crc <= bfb_pkg::CRC_INIT;
            st_ff.rx_crc <= bfb_pkg::CRC_INIT;
            st_ff.hdr.dest <= bfb_pkg::BROADCAST_DESTINATION_VALUE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign phy_tx_valid = st_ff.out_v;
    assign phy_tx = st_ff.out;
    assign up_rx_valid = st_ff.up_v;
    assign up_rx = st_ff.up;
    assign rx_crc_err = st_ff.err_pulse;
    assign tx_hdr = st_ff.hdr;
    assign tx_hdr_valid = st_ff.hdr_v;
    assign cipher_key_sel = st_ff.key_sel;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_beacon_hdr_fixed: assert property (tx_hdr_valid && tx_hdr.frame_type == bfb_pkg::FTYPE_BEACON |-> !tx_hdr.secure && tx_hdr.ack_policy == 2'b00 && tx_hdr.dest == bfb_pkg::BROADCAST_DESTINATION_VALUE)
        else $error("beacon header fields wrong");
    a_beacon_seq_sfn: assert property (tx_hdr_valid && tx_hdr.frame_type == bfb_pkg::FTYPE_BEACON |-> tx_hdr.seq == $past(st_ff.sfn))
        else $error("beacon sequence not superframe number");
    a_rx_err_flag: assert property (rx_bad |=> rx_crc_err && st_ff.crc_err ##1 !rx_crc_err || $past(rx_bad))
        else $error("check error not flagged");
    a_group_sfn_zero: assert property (group_form |=> st_ff.sfn == 11'h000)
        else $error("superframe number not cleared");
    a_sfn_wrap_zero: assert property (superframe_tick && !group_form && !rx_adopt && st_ff.sfn == 11'h7ff |=> st_ff.sfn == 11'h000)
        else $error("superframe counter did not wrap");
    a_sfn_adopt_max: assert property (rx_adopt && !group_form |=> st_ff.sfn == $past(rx_sfn) && st_ff.sfn > $past(st_ff.sfn))
        else $error("neighbour superframe number not adopted");
    a_slot_byte_out: assert property (st_ff.tx_state == bfb_pkg::TX_FIX && st_ff.cnt == 4'h6 && load |=> phy_tx_valid && phy_tx.data == {$past(st_ff.slot_idx), $past(st_ff.movable), 2'b00})
        else $error("slot descriptor byte wrong");
    a_fcs_first_byte: assert property (st_ff.tx_state == bfb_pkg::TX_FCS && st_ff.cnt == 4'h0 && load |=> phy_tx.data == ~$past(st_ff.crc[7:0]) && !phy_tx.last)
        else $error("check word first octet wrong");
    a_fcs_last_mark: assert property (st_ff.tx_state == bfb_pkg::TX_FCS && st_ff.cnt == bfb_pkg::FCS_LAST && load |=> phy_tx.last && st_ff.tx_state == bfb_pkg::TX_IDLE)
        else $error("frame end not marked");

    c_beacon_sent: cover property (st_ff.beacon && phy_tx_valid && phy_tx.last && phy_tx_ready);
    c_rx_error: cover property (rx_crc_err);
    c_secure_tag: cover property (st_ff.tx_state == bfb_pkg::TX_TAG ##1 st_ff.tx_state == bfb_pkg::TX_FCS);

endmodule

// >>> rtl/bfb_pkg.sv
package bfb_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DEVID_LO = 8'h04;
    localparam logic [7:0] REG_DEVID_HI = 8'h08;
    localparam logic [7:0] REG_BEACON_CFG = 8'h0c;
    localparam logic [7:0] REG_ADDR = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_LAST_FCS = 8'h18;
    localparam logic [7:0] REG_DEST = 8'h1c;

    // control register bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_SECURE = 1;
    localparam int CTRL_GROUP_FORM = 2;
    localparam int CTRL_BEACON = 3;
    localparam int CTRL_SUBTYPE = 4;
    // beacon configuration positions
    localparam int CFG_SLOT = 0;
    localparam int CFG_MOVABLE = 5;
    localparam int CFG_OP_MODE = 8;
    localparam int CFG_SEC_MODE = 10;
    // address register positions
    localparam int ADDR_SRC = 0;
    localparam int ADDR_KEY_SEL = 16;
    // status register positions
    localparam int STAT_SFN = 0;
    localparam int STAT_CRC_ERR = 16;
    localparam int STAT_IE_ORDER = 17;
    localparam int STAT_IE_MISSING = 18;
    localparam int STAT_BUSY = 19;

    // frame check word arithmetic
    localparam logic [31:0] CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_RESIDUE = 32'hc704dd7b;

    // header field values
    localparam logic [15:0] BROADCAST_DESTINATION_VALUE = 16'hffff;
    localparam logic [2:0] FTYPE_BEACON = 3'h0;
    localparam logic [2:0] FTYPE_DATA = 3'h3;
    localparam logic [3:0] SUB_REGULAR = 4'h0;
    localparam logic [3:0] SUB_SIGNALLING = 4'h1;
    localparam logic [3:0] SUB_ECHO = 4'h2;
    localparam logic [1:0] SEC_MODE_RSVD = 2'h3;

    // last octet indices and superframe number width
    localparam logic [3:0] FIX_LAST = 4'h7;
    localparam logic [3:0] TAG_LAST = 4'h7;
    localparam logic [3:0] FCS_LAST = 4'h3;
    localparam int SFN_W = 11;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_KEY = 3'b001,
        TX_FIX = 3'b010,
        TX_BODY = 3'b011,
        TX_TAG = 3'b100,
        TX_FCS = 3'b101
    } bfb_tx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } bfb_byte_t;

    typedef struct packed {
        logic [2:0] prot_ver;
        logic secure;
        logic [1:0] ack_policy;
        logic [2:0] frame_type;
        logic [3:0] subtype;
        logic retry;
        logic [15:0] dest;
        logic [15:0] src;
        logic [2:0] frag;
        logic [SFN_W-1:0] seq;
        logic more_frag;
        logic more_frames;
        logic access_method;
    } bfb_hdr_t;

    function automatic logic [31:0] rev32(input logic [31:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31-i];
        end
        return r;
    endfunction

    // one octet through the divider, least significant bit first
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ rev32(CRC_POLY)) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// >>> verification/bfb_phy_model.sv
`timescale 1ns/10ps
module bfb_phy_model (
    // clock
    input wire logic clock,
    // transmit side
    input wire logic phy_tx_valid,
    input wire bfb_pkg::bfb_byte_t phy_tx,
    output logic phy_tx_ready,
    // receive side
    output logic phy_rx_valid,
    output bfb_pkg::bfb_byte_t phy_rx,
    input wire logic phy_rx_ready
);
    logic [7:0] cap[$];
    initial begin
        phy_tx_ready = 1'b0;
        phy_rx_valid = 1'b0;
        phy_rx = '0;
    end
    // takes octets, stalling every other cycle
    always @(posedge clock) begin
        if (phy_tx_valid && phy_tx_ready) cap.push_back(phy_tx.data);
        phy_tx_ready <= !phy_tx_ready;
    end
    // one octet per accepted transfer, line scrambled once released
    task automatic send(input logic [7:0] d, input logic l);
        @(posedge clock);
        phy_rx_valid <= 1'b1;
        phy_rx <= '{data: d, last: l};
        forever begin
            @(negedge clock);
            if (phy_rx_ready) break;
        end
        @(posedge clock);
        phy_rx_valid <= 1'b0;
        phy_rx <= '{data: ~d, last: ~l};
    endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
    logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, up_tx_valid = 0;
    logic tick = 0, is_bcn = 0, ptv, ptr, prv, prr, utr, crc_err, hv;
    logic [7:0] ks;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, c;
    logic [10:0] rx_sfn = 0;
    bfb_pkg::bfb_byte_t up_tx = '0, ptx, prx;
    bfb_pkg::bfb_hdr_t hdr;
    int bad_count = 0, n_compared = 0, n_err = 0, n_hdr = 0;
    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (crc_err === 1'b1) n_err++;
        if (hv === 1'b1) n_hdr++;
    end
    bfb_frame_builder i_dut (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .up_tx_valid(up_tx_valid),
        .up_tx(up_tx), .up_tx_ready(utr),
        .integrity_tag(64'h0807060504030201),
        .cipher_key_sel(ks), .tx_hdr(hdr), .tx_hdr_valid(hv),
        .phy_tx_valid(ptv), .phy_tx(ptx), .phy_tx_ready(ptr),
        .phy_rx_valid(prv), .phy_rx(prx), .phy_rx_ready(prr),
        .rx_is_beacon(is_bcn), .rx_sfn(rx_sfn), .up_rx_valid(), .up_rx(),
        .up_rx_ready(1'b1), .rx_crc_err(crc_err), .superframe_tick(tick));
    bfb_phy_model i_phy (.clock(clock), .phy_tx_valid(ptv), .phy_tx(ptx),
        .phy_tx_ready(ptr), .phy_rx_valid(prv), .phy_rx(prx),
        .phy_rx_ready(prr));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic put(input logic [7:0] d, input logic l);
        @(posedge clock);
        up_tx_valid <= 1'b1;
        up_tx <= '{data: d, last: l};
        forever begin
            @(negedge clock);
            if (utr) break;
        end
        @(posedge clock);
        up_tx_valid <= 1'b0;
        repeat (30) @(posedge clock);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            tick <= 1'b1;
            @(posedge clock);
            tick <= 1'b0;
        end
    endtask
    // payload octet then the check word of octet a5, low octet first
    task automatic rx5(input logic [7:0] b);
        i_phy.send(b, 1'b0);
        for (int i = 0; i < 4; i++) i_phy.send(c[8*i+:8], i == 3);
        repeat (3) @(posedge clock);
    endtask
    function automatic logic [31:0] crc8(input logic [31:0] r,
                                         input logic [7:0] d);
        for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? (r >> 1) ^ 32'hedb88320 : r >> 1;
        return r;
    endfunction
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #80 resetn = 1'b1;
        c = ~crc8(32'hffffffff, 8'ha5);
        rd(bfb_pkg::REG_STATUS, 32'h0);
        rd(8'h3c, 32'h0);
        wr(bfb_pkg::REG_CTRL, 32'h1);
        put(8'ha5, 1'b1);
        chk(32'(i_phy.cap.size()), 32'h5);
        chk(32'(i_phy.cap[0]), 32'ha5);
        for (int i = 0; i < 4; i++) chk(32'(i_phy.cap[i+1]), 32'(c[8*i+:8]));
        rd(bfb_pkg::REG_LAST_FCS, c);
        is_bcn <= 1'b1;
        rx_sfn <= 11'h7ff;
        rx5(8'ha5);
        rd(bfb_pkg::REG_STATUS, 32'h7ff);
        pulse(1);
        rd(bfb_pkg::REG_STATUS, 32'h0);
        pulse(3);
        rx5(8'h5a);
        chk(32'(n_err), 32'h1);
        rd(bfb_pkg::REG_STATUS, 32'h10003);
        wr(bfb_pkg::REG_STATUS, 32'h10000);
        wr(bfb_pkg::REG_CTRL, 32'h4);
        rd(bfb_pkg::REG_STATUS, 32'h0);
        wr(bfb_pkg::REG_CTRL, 32'h1b);
        put(8'h01, 1'b1);
        chk({hdr.prot_ver, hdr.secure, hdr.ack_policy, hdr.frame_type, hdr.subtype}, 32'h1);
        chk({hdr.dest, 5'h0, hdr.seq}, 32'hffff0000);
        wr(bfb_pkg::REG_DEVID_LO, 32'h44332211);
        wr(bfb_pkg::REG_DEVID_HI, 32'h6655);
        wr(bfb_pkg::REG_BEACON_CFG, 32'h925);
        wr(bfb_pkg::REG_CTRL, 32'h9);
        put(8'h03, 1'b0);
        put(8'h00, 1'b0);
        put(8'h01, 1'b1);
        chk(32'(i_phy.cap[10]), 32'h11);
        chk(32'(i_phy.cap[15]), 32'h66);
        chk(32'(i_phy.cap[16]), 32'h2c);
        chk(32'(i_phy.cap[17]), 32'h09);
        rd(bfb_pkg::REG_STATUS, 32'h60000);
        wr(bfb_pkg::REG_ADDR, 32'h5a0000);
        wr(bfb_pkg::REG_CTRL, 32'h3);
        put(8'h77, 1'b1);
        chk(32'(ks), 32'h5a);
        chk(32'(i_phy.cap[25]), 32'h5a);
        chk(32'(i_phy.cap[27]), 32'h01);
        chk(32'(i_phy.cap.size()), 32'd39);
        chk(32'(n_hdr), 32'h4);
        finish_test;
    end
    initial begin
        #100000 bad_count++;
        finish_test;
    end
endmodule
